// File: hdl/timer_pkg.sv
// Package of register offsets, field layouts, codes and helpers for the dual channel timer.
//
// Behaviour
// - Channel A mode field: 00 compare, 01 capture, 10 PWM/single pulse, 11 timer/counter.
// - Channel B mode field uses the same four codes as channel A.
// - Compare mode, match A: pin action 00 keep, 01 low, 10 high, 11 toggle.
// - Compare mode, match B: same pin actions applied to the channel B pins.
// - PWM mode: action 00 inactive, 01 active, 10 PWM waveform, 11 single pulse.
// - Capture mode: action 00 rising, 01 falling, 10 either edge, 11 none.
// - Compare mode: output control sets start level; timer on rise restores it.
// - Action level equal to start level gives no visible pin change.
// - PWM mode: output control 0 active low, 1 active high; unused in timer mode.
// - Invert bit passes output straight or inverted; no effect in timer mode.
// - Direction flag reads 0 counting up, 1 counting down.
// - Clear source 0 clears on period match or overflow, 1 on match A.
// - Overflow clears only with period value zero; comparator B never clears.
// - Clear source bit is ignored in single pulse and capture modes.
// - Alignment 00 edge; 01 centre up-match, 10 centre down-match, 11 both.
// - Counter low byte register is read only, bits 7 to 0, resets zero.
// - Timer on rising clears the counter; falling holds the count.
// - Period value compares counter top three bits; zero runs to 1024 clocks.
package timer_pkg;

    // ===========================================================
    // Register offsets (byte addresses).
    localparam logic [11:0] OFF_TIMER_CTRL = 12'h000;
    localparam logic [11:0] OFF_CHA_CTRL = 12'h004;
    localparam logic [11:0] OFF_CHB_CTRL = 12'h008;
    localparam logic [11:0] OFF_CNT_LO = 12'h00c;
    localparam logic [11:0] OFF_CNT_HI = 12'h010;
    localparam logic [11:0] OFF_CMP_A = 12'h014;
    localparam logic [11:0] OFF_CMP_B = 12'h018;

    // ===========================================================
    // Field positions.
    localparam int TON_BIT = 3;
    localparam int PER_LSB = 0;
    localparam int MODE_LSB = 6;
    localparam int ACT_LSB = 4;
    localparam int OCTRL_BIT = 3;
    localparam int INV_BIT = 2;
    localparam int DIR_BIT = 1;
    localparam int CLR_BIT = 0;
    localparam int ALIGN_LSB = 0;

    // ===========================================================
    // Reset values.
    localparam logic [3:0] TIMER_CTRL_RST = 4'h0;
    localparam logic [7:0] CH_CTRL_RST = 8'h00;
    localparam logic [9:0] CMP_RST = 10'h000;
    localparam logic [9:0] CNT_RST = 10'h000;

    // ===========================================================
    // Mode, action and alignment codes.
    localparam logic [1:0] MODE_COMPARE = 2'h0;
    localparam logic [1:0] MODE_CAPTURE = 2'h1;
    localparam logic [1:0] MODE_PWM = 2'h2;
    localparam logic [1:0] MODE_TIMER = 2'h3;
    localparam logic [1:0] ACT_KEEP = 2'h0;
    localparam logic [1:0] ACT_LOW = 2'h1;
    localparam logic [1:0] ACT_HIGH = 2'h2;
    localparam logic [1:0] ACT_TOGGLE = 2'h3;
    localparam logic [1:0] PWM_INACTIVE = 2'h0;
    localparam logic [1:0] PWM_ACTIVE = 2'h1;
    localparam logic [1:0] PWM_WAVE = 2'h2;
    localparam logic [1:0] PWM_SINGLE = 2'h3;
    localparam logic [1:0] CAP_RISE = 2'h0;
    localparam logic [1:0] CAP_FALL = 2'h1;
    localparam logic [1:0] CAP_BOTH = 2'h2;
    localparam logic [1:0] CAP_OFF = 2'h3;
    localparam logic [1:0] ALIGN_EDGE = 2'h0;
    localparam logic [1:0] ALIGN_UP = 2'h1;
    localparam logic [1:0] ALIGN_DOWN = 2'h2;
    localparam logic [1:0] ALIGN_BOTH = 2'h3;

    // Last count before the period match; period zero wraps to the overflow value.
    function automatic logic [9:0] top_value(input logic [2:0] period);
        logic [2:0] upper;
        upper = period - 3'h1;
        return {upper, 7'h7f};
    endfunction : top_value

endpackage : timer_pkg

// File: hdl/channel_pin_unit.sv
// One channel's output pin logic for compare, PWM and single pulse modes.
`timescale 1ns/1ps
module channel_pin_unit
    import timer_pkg::*;
(
    input wire logic clk_sys,
    input wire logic srst,
    input wire logic [1:0] modeSel,
    input wire logic [1:0] pinAction,
    input wire logic outCtrl,
    input wire logic invert,
    input wire logic [1:0] align,
    input wire logic onRise,
    input wire logic matchEvt,
    input wire logic periodStart,
    input wire logic countDown,
    output logic pinOut,
    output logic pinOe
);

    logic level;
    logic next_level;
    logic dirOk;
    logic shown;

    // Centre aligned matches count only in the selected direction.
    assign dirOk = (align == ALIGN_EDGE) || (align == ALIGN_BOTH) ||
                   (align == ALIGN_UP && !countDown) || (align == ALIGN_DOWN && countDown);

    // Next logical level: pin level in compare mode, active flag in PWM mode.
    always_comb begin
        next_level = level;
        case (modeSel)
            MODE_COMPARE: begin
                if (onRise) begin
                    next_level = outCtrl;
                end else if (matchEvt) begin
                    case (pinAction)
                        ACT_LOW: next_level = 1'b0;
                        ACT_HIGH: next_level = 1'b1;
                        ACT_TOGGLE: next_level = ~level;
                        default: next_level = level;
                    endcase
                end
            end
            MODE_PWM: begin
                case (pinAction)
                    PWM_INACTIVE: next_level = 1'b0;
                    PWM_ACTIVE: next_level = 1'b1;
                    PWM_WAVE: begin
                        if (onRise) begin
                            next_level = 1'b1;
                        end else if (matchEvt && dirOk && align == ALIGN_BOTH) begin
                            next_level = ~level;
                        end else if (matchEvt && dirOk) begin
                            next_level = 1'b0;
                        end else if (periodStart && align != ALIGN_BOTH) begin
                            next_level = 1'b1;
                        end
                    end
                    PWM_SINGLE: begin
                        if (onRise) begin
                            next_level = 1'b1;
                        end else if (matchEvt) begin
                            next_level = 1'b0;
                        end
                    end
                    default: next_level = level;
                endcase
            end
            default: next_level = level;
        endcase
    end

    assign shown = (modeSel == MODE_PWM) ? (next_level ? outCtrl : ~outCtrl) : next_level;

    // Level and registered pin drive; capture and timer modes release the pin.
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            level <= 1'b0;
            pinOut <= 1'b0;
            pinOe <= 1'b0;
        end else begin
            level <= next_level;
            pinOut <= (modeSel == MODE_COMPARE || modeSel == MODE_PWM) ? (shown ^ invert) : 1'b0;
            pinOe <= (modeSel == MODE_COMPARE || modeSel == MODE_PWM);
        end
    end

endmodule : channel_pin_unit

// File: hdl/timer_dual_channel.sv
// Dual channel 10-bit timer: APB registers, counter, capture and channel pins.
`timescale 1ns/1ps
module timer_dual_channel
    import timer_pkg::*;
(
    input wire logic clk_sys,
    input wire logic srst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic countTick,
    input wire logic chanAPinIn,
    output logic chanAPinOut,
    output logic chanAPinOe,
    input wire logic chanBPin0In,
    output logic chanBPin0Out,
    output logic chanBPin0Oe,
    output logic chanBPin1Out,
    output logic chanBPin1Oe,
    output logic chanBPin2Out,
    output logic chanBPin2Oe
);

    // ===========================================================
    // Register state.
    logic timerOn;
    logic [2:0] period;
    logic [7:0] chanACtrl;
    logic [7:0] chanBCtrl;
    logic [9:0] cmpA;
    logic [9:0] cmpB;
    logic [9:0] cnt;
    logic [9:0] next_cnt;
    logic countDown;
    logic next_countDown;
    logic onPrev;
    logic aPrev;
    logic bPrev;
    logic pinBOut;
    logic pinBOe;

    // Decoded fields.
    logic [1:0] modeA;
    logic [1:0] modeB;
    logic [1:0] actA;
    logic [1:0] actB;
    logic [1:0] align;
    logic clrSel;
    logic onRise;
    logic step;
    logic isSingle;
    logic isCentre;
    logic useClrA;
    logic [9:0] top;
    logic matchA;
    logic matchB;
    logic periodStart;
    logic capA;
    logic capB;
    logic access;
    logic wrEn;

    assign modeA = chanACtrl[MODE_LSB +: 2];
    assign modeB = chanBCtrl[MODE_LSB +: 2];
    assign actA = chanACtrl[ACT_LSB +: 2];
    assign actB = chanBCtrl[ACT_LSB +: 2];
    assign align = chanBCtrl[ALIGN_LSB +: 2];
    assign clrSel = chanACtrl[CLR_BIT];

    // Checks whether a capture edge matches the selected trigger.
    function automatic logic cap_hit(input logic [1:0] sel, input logic rise, input logic fall);
        case (sel)
            CAP_RISE: return rise;
            CAP_FALL: return fall;
            CAP_BOTH: return rise | fall;
            default: return 1'b0;
        endcase
    endfunction : cap_hit

    // ===========================================================
    // APB slave: access phase takes two cycles, answer registered.
    assign access = psel && penable && !pready;
    assign wrEn = psel && penable && pready && pwrite;

    // Read data and error for the access about to complete.
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            pready <= 1'b0;
            prdata <= 32'h0000_0000;
            pslverr <= 1'b0;
        end else begin
            pready <= access;
            if (access) begin
                pslverr <= 1'b0;
                prdata <= 32'h0000_0000;
                case (paddr)
                    OFF_TIMER_CTRL: prdata[3:0] <= {timerOn, period};
                    OFF_CHA_CTRL: prdata[7:0] <= {chanACtrl[7:2], countDown, chanACtrl[CLR_BIT]};
                    OFF_CHB_CTRL: prdata[7:0] <= chanBCtrl;
                    OFF_CNT_LO: prdata[7:0] <= cnt[7:0];
                    OFF_CNT_HI: prdata[1:0] <= cnt[9:8];
                    OFF_CMP_A: prdata[9:0] <= cmpA;
                    OFF_CMP_B: prdata[9:0] <= cmpB;
                    default: pslverr <= 1'b1;
                endcase
            end else begin
                pslverr <= 1'b0;
            end
        end
    end

    // Control register writes; the direction bit of channel A is read only.
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            timerOn <= TIMER_CTRL_RST[TON_BIT];
            period <= TIMER_CTRL_RST[PER_LSB +: 3];
            chanACtrl <= CH_CTRL_RST;
            chanBCtrl <= CH_CTRL_RST;
        end else if (wrEn) begin
            case (paddr)
                OFF_TIMER_CTRL: begin
                    timerOn <= pwdata[TON_BIT];
                    period <= pwdata[PER_LSB +: 3];
                end
                OFF_CHA_CTRL: chanACtrl <= {pwdata[7:2], 1'b0, pwdata[CLR_BIT]};
                OFF_CHB_CTRL: chanBCtrl <= pwdata[7:0];
                default: chanACtrl <= chanACtrl;
            endcase
        end
    end

    // ===========================================================
    // Counter control.
    assign onRise = timerOn && !onPrev;
    assign step = timerOn && !onRise && countTick;
    assign isSingle = (modeA == MODE_PWM) && (actA == PWM_SINGLE);
    assign isCentre = (modeA == MODE_PWM) && !isSingle && (align != ALIGN_EDGE);
    assign useClrA = clrSel && !isSingle && (modeA != MODE_CAPTURE);
    assign top = top_value(period);
    assign matchA = step && (cnt == cmpA);
    assign matchB = step && (cnt == cmpB);
    assign periodStart = step && (next_cnt == CNT_RST);

    // Next count and direction.
    always_comb begin
        next_cnt = cnt;
        next_countDown = isCentre ? countDown : 1'b0; // Only centre aligned counting runs down.
        if (onRise) begin
            next_cnt = CNT_RST;
            next_countDown = 1'b0;
        end else if (step) begin
            if (isCentre) begin
                if (countDown) begin
                    next_cnt = (cnt == CNT_RST) ? cnt + 10'h001 : cnt - 10'h001;
                    next_countDown = (cnt != CNT_RST);
                end else begin
                    next_cnt = (cnt == top) ? cnt - 10'h001 : cnt + 10'h001;
                    next_countDown = (cnt == top);
                end
            end else if (useClrA && cnt == cmpA) begin
                next_cnt = CNT_RST;
            end else if (!useClrA && cnt == top) begin
                next_cnt = CNT_RST;
            end else begin
                next_cnt = cnt + 10'h001;
            end
        end
    end

    // Counter, direction and switch-on edge history; off holds the count.
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            cnt <= CNT_RST;
            countDown <= 1'b0;
            onPrev <= 1'b0;
        end else begin
            cnt <= next_cnt;
            countDown <= next_countDown;
            onPrev <= timerOn;
        end
    end

    // ===========================================================
    // Capture inputs.
    // capture edge select
    assign capA = timerOn && (modeA == MODE_CAPTURE) && cap_hit(actA, chanAPinIn && !aPrev, !chanAPinIn && aPrev);
    assign capB = timerOn && (modeB == MODE_CAPTURE) && cap_hit(actB, chanBPin0In && !bPrev, !chanBPin0In && bPrev);

    // Pin history for edge detection.
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            aPrev <= 1'b0;
            bPrev <= 1'b0;
        end else begin
            aPrev <= chanAPinIn;
            bPrev <= chanBPin0In;
        end
    end

    // Compare values: a capture takes precedence over a software write.
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            cmpA <= CMP_RST;
            cmpB <= CMP_RST;
        end else begin
            if (capA) begin
                cmpA <= cnt;
            end else if (wrEn && paddr == OFF_CMP_A) begin
                cmpA <= pwdata[9:0];
            end
            if (capB) begin
                cmpB <= cnt;
            end else if (wrEn && paddr == OFF_CMP_B) begin
                cmpB <= pwdata[9:0];
            end
        end
    end

    // ===========================================================
    // Channel pins; channel B drives its three pins alike.
    channel_pin_unit chanAUnit (
        .clk_sys(clk_sys),
        .srst(srst),
        .modeSel(modeA),
        .pinAction(actA),
        .outCtrl(chanACtrl[OCTRL_BIT]),
        .invert(chanACtrl[INV_BIT]),
        .align(align),
        .onRise(onRise),
        .matchEvt(matchA),
        .periodStart(periodStart),
        .countDown(countDown),
        .pinOut(chanAPinOut),
        .pinOe(chanAPinOe)
    );

    channel_pin_unit chanBUnit (
        .clk_sys(clk_sys),
        .srst(srst),
        .modeSel(modeB),
        .pinAction(actB),
        .outCtrl(chanBCtrl[OCTRL_BIT]),
        .invert(chanBCtrl[INV_BIT]),
        .align(align),
        .onRise(onRise),
        .matchEvt(matchB),
        .periodStart(periodStart),
        .countDown(countDown),
        .pinOut(pinBOut),
        .pinOe(pinBOe)
    );

    // Fan the channel B flop outputs to its pins.
    assign chanBPin0Out = pinBOut;
    assign chanBPin0Oe = pinBOe;
    assign chanBPin1Out = pinBOut;
    assign chanBPin1Oe = pinBOe;
    assign chanBPin2Out = pinBOut;
    assign chanBPin2Oe = pinBOe;

    // ===========================================================
    // Checks.
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (srst);

    sequence s_switch_on;
        !timerOn ##1 timerOn;
    endsequence

    sequence s_cmp_hit_low;
        (modeA == MODE_COMPARE) && actA == ACT_LOW && matchA && !onRise;
    endsequence

    a_on_clears: assert property (s_switch_on |=> cnt == CNT_RST)
        else $error("counter not cleared after switch on");

    a_off_holds: assert property (!timerOn && $past(!timerOn) |=> $stable(cnt))
        else $error("counter moved while timer off");

    a_clear_on_a: assert property (step && useClrA && !isCentre && cnt == cmpA |=> cnt == CNT_RST)
        else $error("match A did not clear counter");

    a_overflow_wrap: assert property (step && !useClrA && !isCentre && period == 3'h0 && cnt == 10'h3ff
        |=> cnt == CNT_RST)
        else $error("overflow did not wrap to zero");

    a_period_clear: assert property (step && !useClrA && !isCentre && period == 3'h2 && cnt == 10'h0ff
        |=> cnt == CNT_RST)
        else $error("period match did not clear counter");

    a_dir_edge: assert property (!isCentre |=> !countDown || isCentre)
        else $error("direction down outside centre mode");

    a_low_byte: assert property (access && paddr == OFF_CNT_LO |=> pready && prdata == {24'h0, $past(cnt[7:0])})
        else $error("counter low byte read wrong");

    a_match_low: assert property (s_cmp_hit_low |=> chanAPinOut == chanACtrl[INV_BIT] && chanAPinOe)
        else $error("match with low action did not drive low");

    a_start_level: assert property (s_switch_on ##0 (modeA == MODE_COMPARE)
        |=> chanAPinOut == (chanACtrl[OCTRL_BIT] ^ chanACtrl[INV_BIT]))
        else $error("pin not at start level after switch on");

    a_timer_release: assert property (modeA == MODE_TIMER && $past(modeA == MODE_TIMER) |-> !chanAPinOe && !chanAPinOut)
        else $error("pin driven in timer mode");

    a_capture_rise: assert property (capA |=> cmpA == $past(cnt))
        else $error("capture did not store counter");

    a_pwm_inactive: assert property (modeA == MODE_PWM && actA == PWM_INACTIVE
        |=> chanAPinOut == (~$past(chanACtrl[OCTRL_BIT]) ^ $past(chanACtrl[INV_BIT])))
        else $error("forced inactive level wrong");

endmodule : timer_dual_channel

// File: test/pin_partner.sv
// Far side pin model: drives the capture inputs and resolves the shared pin wires.
`timescale 1ns/1ps
module pin_partner (
    input wire logic clk_sys,
    input wire logic drvLvl,
    input wire logic aOut,
    input wire logic aOe,
    input wire logic b0Out,
    input wire logic b0Oe,
    output logic aIn,
    output logic b0In
);
    logic extLvl = 1'b0;

    // The external level moves just after a clock edge, like a real source on the board.
    always_ff @(posedge clk_sys) begin
        extLvl <= drvLvl;
    end

    // wire level resolution
    // The wire follows the device while it drives, otherwise the external level.
    assign aIn = aOe ? aOut : extLvl;
    assign b0In = b0Oe ? b0Out : extLvl;
endmodule : pin_partner

// File: test/tb_timer_dual_channel_mode_control.sv
// Self-checking bench for the dual channel timer mode and pin control.
`timescale 1ns/1ps
module tb_timer_dual_channel_mode_control;
    import timer_pkg::*;
    logic clk_sys = 1'b0;
    logic srst = 1'b1;
    logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, countTick = 1'b1, drvLvl = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata, rd, cnt;
    logic pready, pslverr, errFlag, oc, inv, lvl, seenDown;
    logic aIn, aOut, aOe, b0In, b0Out, b0Oe, b1Out, b1Oe, b2Out, b2Oe;
    logic [1:0] act, expCls;
    logic [7:0] mx;
    int n_mismatch = 0, checks_done = 0, hi;

    // ===========================================================
    // Clock, design and far side.
    always #2 clk_sys = ~clk_sys;

    timer_dual_channel timer_dual_channel_inst (.clk_sys(clk_sys), .srst(srst), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .countTick(countTick), .chanAPinIn(aIn),
        .chanAPinOut(aOut), .chanAPinOe(aOe), .chanBPin0In(b0In), .chanBPin0Out(b0Out),
        .chanBPin0Oe(b0Oe), .chanBPin1Out(b1Out), .chanBPin1Oe(b1Oe), .chanBPin2Out(b2Out),
        .chanBPin2Oe(b2Oe));

    pin_partner pin_partner_inst (.clk_sys(clk_sys), .drvLvl(drvLvl), .aOut(aOut), .aOe(aOe),
        .b0Out(b0Out), .b0Oe(b0Oe), .aIn(aIn), .b0In(b0In));

    // ===========================================================
    // Shared tasks.
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            n_mismatch++;
            $display("Error %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk

    // One APB transfer; the setup starts one edge after any earlier release.
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk_sys);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk_sys);
        penable <= 1'b1;
        do begin
            @(posedge clk_sys);
            n++;
        end while (pready !== 1'b1 && n < 20);
        rd = prdata;
        errFlag = pslverr;
        chk(n < 20, 1);
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    // Switches the timer off, sets both channels, then switches it on again.
    task automatic cfg(input logic [7:0] a, input logic [7:0] b, input logic [2:0] per);
        apb(1'b1, OFF_TIMER_CTRL, 32'h0);
        apb(1'b1, OFF_CHA_CTRL, {24'h0, a});
        apb(1'b1, OFF_CHB_CTRL, {24'h0, b});
        apb(1'b1, OFF_TIMER_CTRL, {28'h0, 1'b1, per});
        repeat (3) @(posedge clk_sys);
    endtask : cfg

    // Largest counter low byte seen over a run of reads.
    task automatic peak(input int k);
        mx = 8'h00;
        repeat (k) begin
            apb(1'b0, OFF_CNT_LO, 32'h0);
            if (rd[7:0] > mx) mx = rd[7:0];
        end
    endtask : peak

    task automatic complete_run();
        if (n_mismatch == 0 && checks_done > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : complete_run

    // ===========================================================
    // Test sequence.
    initial begin
        repeat (10) @(posedge clk_sys);
        srst <= 1'b0;
        apb(1'b0, OFF_CHA_CTRL, 32'h0);
        chk(rd, 32'h0);
        apb(1'b0, OFF_CNT_LO, 32'h0);
        chk(rd, 32'h0);
        apb(1'b0, 12'h01c, 32'h0);
        chk({31'h0, errFlag}, 32'h1);
        chk(rd, 32'h0);
        apb(1'b1, OFF_CNT_LO, 32'h5a);
        apb(1'b0, OFF_CNT_LO, 32'h0);
        chk(rd, 32'h0);
        apb(1'b1, OFF_CHA_CTRL, 32'hff);
        apb(1'b0, OFF_CHA_CTRL, 32'h0);
        chk(rd, 32'hfd);
        for (int i = 0; i < 4; i++) begin
            apb(1'b1, OFF_CHB_CTRL, {30'h0, i[1:0]});
            apb(1'b0, OFF_CHB_CTRL, 32'h0);
            chk(rd, {30'h0, i[1:0]});
        end
        // Compare mode: every pin action against both start levels.
        apb(1'b1, OFF_CMP_A, 32'd20);
        apb(1'b1, OFF_CMP_B, 32'd30);
        for (int i = 0; i < 8; i++) begin
            act = i[1:0];
            oc = i[2];
            inv = i[0];
            cfg({MODE_COMPARE, act, oc, inv, 2'b00}, {MODE_COMPARE, act, oc, inv, 2'b00}, 3'h0);
            chk({aOe, b2Oe, aOut, b2Out}, {2'b11, {2{oc ^ inv}}});
            repeat (60) @(posedge clk_sys);
            lvl = act == ACT_KEEP ? oc : act == ACT_LOW ? 1'b0 : act == ACT_HIGH ? 1'b1 : !oc;
            chk({aOut, b0Out, b1Out, b2Out}, {4{lvl ^ inv}});
        end
        apb(1'b1, OFF_TIMER_CTRL, 32'h0);
        apb(1'b0, OFF_CNT_LO, 32'h0);
        cnt = rd;
        repeat (10) @(posedge clk_sys);
        apb(1'b0, OFF_CNT_LO, 32'h0);
        chk(rd, cnt);
        apb(1'b1, OFF_TIMER_CTRL, 32'h8);
        repeat (3) @(posedge clk_sys);
        chk({aOut, b0Out}, 2'b00);
        apb(1'b0, OFF_CNT_LO, 32'h0);
        chk(rd < 16, 1);
        // Counter clear sources and period.
        apb(1'b1, OFF_CMP_A, 32'd50);
        apb(1'b1, OFF_CMP_B, 32'd10);
        cfg(8'h01, 8'h00, 3'h1);
        peak(60);
        chk(mx inside {[44:50]}, 1);
        cfg(8'h00, 8'h00, 3'h1);
        peak(60);
        chk(mx inside {[120:127]}, 1);
        cfg(8'h00, 8'h00, 3'h0);
        peak(90);
        chk(mx > 8'd200, 1);
        // Capture mode: a rise then a fall on both capture inputs.
        for (int c = 0; c < 4; c++) begin
            apb(1'b1, OFF_CMP_A, 32'h3ff);
            apb(1'b1, OFF_CMP_B, 32'h3ff);
            cfg({MODE_CAPTURE, c[1:0], 4'h1}, {MODE_CAPTURE, c[1:0], 4'h0}, 3'h0);
            repeat (20) @(posedge clk_sys);
            drvLvl <= 1'b1;
            repeat (40) @(posedge clk_sys);
            drvLvl <= 1'b0;
            repeat (20) @(posedge clk_sys);
            expCls = c == 0 ? 2'd1 : c == 3 ? 2'd0 : 2'd2;
            chk({aOe, b0Oe}, 2'b00);
            apb(1'b0, OFF_CMP_A, 32'h0);
            chk(rd == 32'h3ff ? 2'd0 : rd < 45 ? 2'd1 : 2'd2, expCls);
            apb(1'b0, OFF_CMP_B, 32'h0);
            chk(rd == 32'h3ff ? 2'd0 : rd < 45 ? 2'd1 : 2'd2, expCls);
        end
        // PWM mode: forced levels, then a waveform and a centre aligned count.
        for (int i = 0; i < 8; i++) begin
            act = {1'b0, i[0]};
            oc = i[1];
            inv = i[2];
            cfg({MODE_PWM, act, oc, inv, 2'b00}, {MODE_PWM, act, oc, inv, 2'b00}, 3'h0);
            lvl = (act == PWM_ACTIVE) ? oc : !oc;
            chk({aOut, b0Out, b2Out}, {3{lvl ^ inv}});
        end
        apb(1'b1, OFF_CMP_A, 32'd32);
        cfg({MODE_PWM, PWM_WAVE, 4'h8}, {MODE_PWM, PWM_WAVE, 2'b10, ALIGN_EDGE}, 3'h1);
        repeat (10) @(posedge clk_sys);
        hi = 0;
        repeat (128) begin
            @(posedge clk_sys);
            hi += aOut;
        end
        chk(hi inside {[31:33]}, 1);
        // Single pulse: active from switch on until the channel A match.
        cfg({MODE_PWM, PWM_SINGLE, 4'h8}, {MODE_PWM, PWM_SINGLE, 4'h8}, 3'h0);
        chk(aOut, 1);
        repeat (60) @(posedge clk_sys);
        chk(aOut, 0);
        cfg({MODE_PWM, PWM_WAVE, 4'h8}, {MODE_PWM, PWM_WAVE, 2'b10, ALIGN_BOTH}, 3'h1);
        seenDown = 1'b0;
        repeat (100) begin
            apb(1'b0, OFF_CHA_CTRL, 32'h0);
            seenDown |= rd[1];
        end
        chk(seenDown, 1);
        cfg({MODE_TIMER, 6'h0c}, {MODE_TIMER, 6'h0c}, 3'h0);
        chk({aOe, b0Oe, b1Oe, b2Oe, aOut, b0Out}, 6'h0);
        complete_run();
    end

    // Cuts a hang short well beyond the expected run length.
    initial begin
        repeat (20000) @(posedge clk_sys);
        n_mismatch++;
        complete_run();
    end
endmodule : tb_timer_dual_channel_mode_control
